// ### design/sosc_clock_select_irq.v
// Slow oscillator controller: watchdog counter clock, RTC clock selection,
// ready interrupts and wake-up.
// Assumes oscillator ticks and ready bits are asynchronous to ref_clk and are
// synchronised here; watchdog and RTC consume one-cycle tick enables.
// Operation
// RULE1: Always-running 1.024kHz tick gated for watchdog
// RULE2: RTC clock chosen by select field
// RULE3: Software picks RTC clock before enabling counter
// RULE4: Crystal ready rising edge sets flag
// RULE5: Internal oscillator ready rising edge sets flag
// RULE6: Enabled pending flags drive wake-up request
// RULE7: Enable set/clear registers share one state
// RULE8: Request when flag and enable both set
// RULE9: Request holds until clear, disable, reset
// RULE10: One shared request line; flags readable
// RULE11: Software enables watchdog clock before use
// RULE12: Watchdog clock sourced from ultra-low-power oscillator
// RULE13: Write one clears flag; event wins
`timescale 1ns/1ns
`default_nettype none
`include "sosc_regs.vh"

module sosc_clock_select_irq #(
  parameter WDT_DIV = `SOSC_WDT_DIV
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst_b,
  // Avalon-MM slave
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // Oscillator ticks and ready levels (asynchronous)
  input  wire        ultra_low_power_osc,
  input  wire        ultra_low_power_osc_1k,
  input  wire        internal_osc_32k,
  input  wire        internal_osc_1k,
  input  wire        crystal_osc_32k,
  input  wire        crystal_osc_1k,
  input  wire        crystal_ready,
  input  wire        internal_osc_ready,
  // Watchdog clock request and clock enables
  input  wire        watchdog_clock_request,
  output reg         watchdog_counter_clock,
  output reg         rtc_counter_clock,
  // Interrupt and wake-up
  output reg         irq,
  output reg         wakeup_request
);

  localparam NS = 8;
  localparam [NS-1:0] ZERO = {NS{1'b0}};

  // Sync order: ulp32, ulp1k, int32, int1k, x32, x1k, xrdy, irdy
  wire [NS-1:0] async_in = {internal_osc_ready, crystal_ready,
                            crystal_osc_1k, crystal_osc_32k,
                            internal_osc_1k, internal_osc_32k,
                            ultra_low_power_osc_1k, ultra_low_power_osc};
  reg  [NS-1:0] sync1_q;
  reg  [NS-1:0] sync2_q;
  reg  [NS-1:0] sync3_q;

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= ZERO;
      sync2_q <= ZERO;
      sync3_q <= ZERO;
    end else begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // One-cycle rising-edge pulses from the second stage onward
  wire [NS-1:0] rise = sync2_q & ~sync3_q;
  wire          ulp_tick = rise[0];

  // Registers
  reg  [`SOSC_IRQ_WIDTH-1:0]    irq_en_q;
  reg  [`SOSC_IRQ_WIDTH-1:0]    flags_q;
  reg  [`SOSC_RTC_SEL_WIDTH-1:0] rtc_sel_q;
  reg                           wdt_en_q;
  reg  [7:0]                    wdt_div_q;

  function sel_hit;
    input [7:0] addr;
    input [7:0] offs;
    begin
      sel_hit = (addr == offs);
    end
  endfunction

  // Single-cycle answer: accept on first cycle, release waitrequest after.
  // A write lands at the edge where the master sees waitrequest low.
  wire access = (avs_read | avs_write) & avs_waitrequest;
  wire wr_lo  = avs_write & ~avs_waitrequest & avs_byteenable[0];
  wire wr_en_set = wr_lo & sel_hit(avs_address, `SOSC_IRQ_ENABLE_SET);
  wire wr_en_clr = wr_lo & sel_hit(avs_address, `SOSC_IRQ_ENABLE_CLEAR);
  wire wr_flags  = wr_lo & sel_hit(avs_address, `SOSC_INTERRUPT_FLAGS);
  wire wr_rtc    = wr_lo & sel_hit(avs_address, `SOSC_RTC_CLOCK_SELECT);
  wire wr_wdt    = wr_lo & sel_hit(avs_address, `SOSC_WDT_CLOCK_CTRL);

  wire [`SOSC_IRQ_WIDTH-1:0] wdata = avs_writedata[`SOSC_IRQ_WIDTH-1:0];
  wire [`SOSC_IRQ_WIDTH-1:0] ready_rise =
    {rise[7], rise[6]};                                       // [RULE4] [RULE5]

  reg [31:0] rdata_d;
  always @* begin
    rdata_d = 32'h0;
    case (avs_address)
      `SOSC_IRQ_ENABLE_SET,
      `SOSC_IRQ_ENABLE_CLEAR: rdata_d[`SOSC_IRQ_WIDTH-1:0] = irq_en_q;
      `SOSC_INTERRUPT_FLAGS:  rdata_d[`SOSC_IRQ_WIDTH-1:0] = flags_q; // [RULE10]
      `SOSC_STATUS:           rdata_d[`SOSC_IRQ_WIDTH-1:0] = sync3_q[7:6];
      `SOSC_RTC_CLOCK_SELECT: rdata_d[`SOSC_RTC_SEL_WIDTH-1:0] = rtc_sel_q;
      `SOSC_WDT_CLOCK_CTRL:   rdata_d[`SOSC_BIT_WDT_ENABLE] = wdt_en_q;
      default:                rdata_d = 32'h0;
    endcase
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else begin
      avs_waitrequest <= ~access;
      if (access && avs_read)
        avs_readdata <= rdata_d;
    end
  end

  // Enable, flags and configuration
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_en_q  <= {`SOSC_IRQ_WIDTH{1'b0}};
      flags_q   <= {`SOSC_IRQ_WIDTH{1'b0}};
      rtc_sel_q <= `SOSC_RTC_SEL_RESET;
      wdt_en_q  <= 1'b0;
    end else begin
      // Set and clear share one enable; a clear writes after a set
      irq_en_q <= (irq_en_q | (wr_en_set ? wdata : 2'h0))
                  & ~(wr_en_clr ? wdata : 2'h0);              // [RULE7]
      flags_q  <= (flags_q & ~(wr_flags ? wdata : 2'h0))
                  | ready_rise;                               // [RULE13]
      if (wr_rtc)
        rtc_sel_q <= avs_writedata[`SOSC_RTC_SEL_WIDTH-1:0]; // [RULE2]
      if (wr_wdt)
        wdt_en_q <= avs_writedata[`SOSC_BIT_WDT_ENABLE];
    end
  end

  // 1.024 kHz tick from the free-running ultra-low-power oscillator
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_div_q <= 8'h0;
    end else if (ulp_tick) begin                              // [RULE12]
      if (wdt_div_q == WDT_DIV - 1)
        wdt_div_q <= 8'h0;
      else
        wdt_div_q <= wdt_div_q + 8'h1;
    end
  end

  wire wdt_tick = ulp_tick && (wdt_div_q == WDT_DIV - 1);

  // RTC tick mux; every oscillator output is a legal source
  reg rtc_tick;
  always @* begin
    case (rtc_sel_q)
      `SOSC_RTC_SEL_ULP_1K:   rtc_tick = rise[1];
      `SOSC_RTC_SEL_ULP_32K:  rtc_tick = rise[0];
      `SOSC_RTC_SEL_INT_1K:   rtc_tick = rise[3];
      `SOSC_RTC_SEL_INT_32K:  rtc_tick = rise[2];
      `SOSC_RTC_SEL_XTAL_1K:  rtc_tick = rise[5];
      `SOSC_RTC_SEL_XTAL_32K: rtc_tick = rise[4];
      default:                rtc_tick = 1'b0;                // [RULE2]
    endcase
  end

  wire pending = |(flags_q & irq_en_q);                       // [RULE8] [RULE9]

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_counter_clock <= 1'b0;
      rtc_counter_clock      <= 1'b0;
      irq                    <= 1'b0;
      wakeup_request         <= 1'b0;
    end else begin
      watchdog_counter_clock <= wdt_tick & wdt_en_q
                                & watchdog_clock_request;     // [RULE1]
      rtc_counter_clock      <= rtc_tick;
      irq                    <= pending;                      // [RULE10]
      wakeup_request         <= pending;                      // [RULE6]
    end
  end

endmodule // sosc_clock_select_irq
`default_nettype wire

// ### design/sosc_regs.vh
// Register map, field positions and timing constants of the slow oscillator
// clock select and interrupt block.
// Assumes a 32-bit Avalon-MM slave whose address is the byte offset itself.
`ifndef SOSC_REGS_VH
`define SOSC_REGS_VH

// Byte offsets
`define SOSC_IRQ_ENABLE_CLEAR   8'h00
`define SOSC_IRQ_ENABLE_SET     8'h04
`define SOSC_INTERRUPT_FLAGS    8'h08
`define SOSC_STATUS             8'h0c
`define SOSC_RTC_CLOCK_SELECT   8'h10
`define SOSC_WDT_CLOCK_CTRL     8'h14

// Interrupt, flag and status bit positions
`define SOSC_BIT_CRYSTAL_READY  0
`define SOSC_BIT_INTERNAL_READY 1
`define SOSC_IRQ_WIDTH          2

// Watchdog clock control bit
`define SOSC_BIT_WDT_ENABLE     0

// RTC clock select field
`define SOSC_RTC_SEL_WIDTH      3
`define SOSC_RTC_SEL_RESET      3'h0
`define SOSC_RTC_SEL_ULP_1K     3'h0
`define SOSC_RTC_SEL_ULP_32K    3'h1
`define SOSC_RTC_SEL_INT_1K     3'h2
`define SOSC_RTC_SEL_INT_32K    3'h3
`define SOSC_RTC_SEL_XTAL_1K    3'h4
`define SOSC_RTC_SEL_XTAL_32K   3'h5

// Watchdog counter clock: 1.024 kHz as a divide of the 32.768 kHz tick
`define SOSC_WDT_HZ             1024
`define SOSC_ULP_HZ             32768
`define SOSC_WDT_DIV            (`SOSC_ULP_HZ / `SOSC_WDT_HZ)

`endif

// ### bench/sosc_chk_asserts.sv
// Port checker for the slow oscillator clock block.
// Assumes a bind onto sosc_clock_select_irq; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module sosc_chk (
  input wire logic        ref_clk, rst_b, avs_read, avs_write,
  input wire logic [7:0]  avs_address,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest, watchdog_clock_request,
  input wire logic        watchdog_counter_clock, rtc_counter_clock,
  input wire logic        irq, wakeup_request
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  bus_answer_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no bus answer");
  answer_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer too long");
  unmapped_zero_a: assert property (
    avs_read && avs_waitrequest && avs_address > 8'h14
    |=> avs_readdata == 32'h0) else $error("unmapped read not zero");
  wake_follow_a: assert property (wakeup_request == irq)
    else $error("wake differs from irq");
  irq_hold_a: assert property ($fell(irq) |-> $past(avs_write, 2))
    else $error("irq dropped alone");
  wdt_gate_a: assert property (
    !watchdog_clock_request [*3] |-> !watchdog_counter_clock)
    else $error("watchdog tick unrequested");
  wdt_pulse_a: assert property (
    watchdog_counter_clock |=> !watchdog_counter_clock)
    else $error("watchdog tick too long");
  rtc_pulse_a: assert property (rtc_counter_clock |=> !rtc_counter_clock)
    else $error("rtc tick too long");
  cover property ($rose(irq));
  cover property ($fell(irq));
  cover property (watchdog_counter_clock);
endmodule // sosc_chk
`default_nettype wire

// ### bench/sosc_osc_model.sv
// Oscillators and ready levels seen by the slow oscillator block.
// Assumes ticks far below a quarter of ref_clk; ready follows go.
`timescale 1ns/1ns
`default_nettype none
module sosc_osc_model (
  input  wire logic       ref_clk, xtal_go, int_go,
  output wire logic [5:0] osc,
  output var  logic       xtal_rdy, int_rdy
);
  logic [9:0] cnt_q = 10'h0;
  // ulp 32k, ulp 1k, int 32k, int 1k, xtal 32k, xtal 1k
  assign osc = {cnt_q[9], cnt_q[5], cnt_q[8], cnt_q[4], cnt_q[7], cnt_q[3]};
  always @(posedge ref_clk) begin
    cnt_q <= cnt_q + 10'h1;
    xtal_rdy <= xtal_go;
    int_rdy <= int_go;
  end
endmodule // sosc_osc_model
`default_nettype wire

// ### bench/sosc_clock_select_irq_tb.sv
// Self-checking bench for the slow oscillator clock block.
// Assumes WDT_DIV of 2 and the oscillator model beside the design.
`timescale 1ns/1ns
`default_nettype none
module sosc_clock_select_irq_tb;
  logic ref_clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0] avs_address = 8'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic avs_waitrequest, wdt_req = 1'b0, xtal_go = 1'b0, int_go = 1'b0;
  logic wdt_clk, rtc_clk, irq, wake, xtal_rdy, int_rdy;
  logic [5:0] osc;
  int bad_count = 0, cmp_count = 0, cyc = 0, n_rtc = 0, n_wdt = 0, i;
  logic [71:0] rows [0:5] = '{{8'h10, 32'h5, 32'h5}, {8'h10, 32'hff, 32'h7},
    {8'h04, 32'h3, 32'h3}, {8'h00, 32'h1, 32'h2}, {8'h14, 32'h1, 32'h1},
    {8'h40, 32'hff, 32'h0}};
  sosc_clock_select_irq #(.WDT_DIV(2)) i_dut (.ref_clk(ref_clk),
    .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(be), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ultra_low_power_osc(osc[0]),
    .ultra_low_power_osc_1k(osc[1]), .internal_osc_32k(osc[2]),
    .internal_osc_1k(osc[3]), .crystal_osc_32k(osc[4]),
    .crystal_osc_1k(osc[5]), .crystal_ready(xtal_rdy),
    .internal_osc_ready(int_rdy), .watchdog_clock_request(wdt_req),
    .watchdog_counter_clock(wdt_clk), .rtc_counter_clock(rtc_clk),
    .irq(irq), .wakeup_request(wake));
  sosc_osc_model i_osc (.ref_clk(ref_clk), .xtal_go(xtal_go),
    .int_go(int_go), .osc(osc), .xtal_rdy(xtal_rdy), .int_rdy(int_rdy));
  initial forever #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    n_rtc += rtc_clk;
    n_wdt += wdt_clk;
    if (cyc == 20000) begin
      bad_count++;
      summarize;
    end
  end
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    for (i = 0; i < 6; i++) begin
      bus(1'b1, rows[i][71:64], rows[i][63:32]);
      bus(1'b0, rows[i][71:64], 32'h0);
      chk(q, rows[i][31:0]);
    end
    be <= 4'h0;
    bus(1'b1, 8'h14, 32'h0);
    be <= 4'hf;
    bus(1'b0, 8'h14, 32'h0);
    chk(q, 32'h1);
    $display("register test done");
    wdt_req <= 1'b1;
    n_wdt = 0;
    repeat (320) @(posedge ref_clk);
    chk(n_wdt >= 9 && n_wdt <= 11, 1'b1);
    wdt_req <= 1'b0;
    repeat (4) @(posedge ref_clk);
    n_wdt = 0;
    repeat (100) @(posedge ref_clk);
    chk(n_wdt, 0);
    $display("watchdog test done");
    for (i = 0; i < 8; i++) begin
      bus(1'b1, 8'h10, i);
      repeat (8) @(posedge ref_clk);
      n_rtc = 0;
      repeat (1100) @(posedge ref_clk);
      chk(n_rtc != 0, i < 6);
    end
    $display("rtc select test done");
    xtal_go <= 1'b1;
    repeat (8) @(posedge ref_clk);
    bus(1'b0, 8'h08, 32'h0);
    chk(q, 32'h1);
    chk(irq, 1'b0);
    bus(1'b1, 8'h04, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk({wake, irq}, 2'b11);
    int_go <= 1'b1;
    repeat (8) @(posedge ref_clk);
    bus(1'b0, 8'h08, 32'h0);
    chk(q, 32'h3);
    bus(1'b0, 8'h0c, 32'h0);
    chk(q, 32'h3);
    bus(1'b1, 8'h08, 32'h1);
    bus(1'b0, 8'h08, 32'h0);
    chk(q, 32'h2);
    chk(irq, 1'b1);
    bus(1'b1, 8'h00, 32'h2);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b0);
    bus(1'b1, 8'h04, 32'h2);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b0);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    bus(1'b0, 8'h04, 32'h0);
    chk(q, 32'h0);
    $display("interrupt test done");
    summarize;
  end
endmodule // sosc_clock_select_irq_tb
bind sosc_clock_select_irq sosc_chk i_chk (.ref_clk(ref_clk), .rst_b(rst_b),
  .avs_read(avs_read), .avs_write(avs_write), .avs_address(avs_address),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .watchdog_clock_request(watchdog_clock_request),
  .watchdog_counter_clock(watchdog_counter_clock),
  .rtc_counter_clock(rtc_counter_clock), .irq(irq),
  .wakeup_request(wakeup_request));
`default_nettype wire
